// File: fwcc_cfg.svh
// offsets, field positions, reset values and limits of the flash command block
`ifndef FWCC_CFG_SVH
`define FWCC_CFG_SVH
`define FWCC_OFS_CMD_HIGH 8'h00
`define FWCC_OFS_CMD_LOW 8'h04
`define FWCC_OFS_ADDR 8'h08
`define FWCC_OFS_DATA0 8'h0C
`define FWCC_OFS_DATA1 8'h10
`define FWCC_OFS_SECTOR 8'h14
`define FWCC_OFS_ERROR 8'h18
`define FWCC_BIT_WRITE_START 15
`define FWCC_BIT_SUSPEND 14
`define FWCC_BIT_WORD 13
`define FWCC_BIT_DWORD 12
`define FWCC_BIT_ERASE 11
`define FWCC_BIT_PROTECT 8
`define FWCC_BIT_MODULE 7
`define FWCC_BIT_BUSY_B0 5
`define FWCC_BIT_BUSY_B1 6
`define FWCC_BIT_LOCK 4
`define FWCC_BIT_BUSY_B2 1
`define FWCC_BIT_BUSY_B3 2
`define FWCC_BIT_OP_ERROR 0
`define FWCC_BIT_SEQ_ERROR 1
`define FWCC_BIT_TEST_SECTOR 10
`define FWCC_SECT_B0_HI 9
`define FWCC_SECT_B2_HI 2
`define FWCC_SECT_B3_LO 16
`define FWCC_SECT_B3_HI 17
`define FWCC_BANK_ADDR_BIT 17
`define FWCC_PROT_LO 24'h0EDFB0
`define FWCC_PROT_HI 24'h0EDFBF
`define FWCC_INVALID_DATA 32'hFFFFFFFF
`define FWCC_RST_WORD 32'h00000000
`define FWCC_RST_ADDR 24'h000000
`define FWCC_RST_BUSY 4'h0
`endif

// File: fwcc_pkg.sv
// types shared by the flash command block and its phase sequencer
package fwcc_pkg;
    typedef enum logic [2:0] {
        op_none, op_word, op_dword, op_preprog, op_erase, op_protect
    } fwcc_code_t;
    typedef enum logic [2:0] {
        mode_idle, mode_run, mode_psusp, mode_esusp, mode_pine
    } fwcc_mode_t;
endpackage

// File: fwcc_opseq.sv
// phase sequencer: issues flash macro phases, handles suspend and resume
`timescale 1ns/1ps
`default_nettype none
module fwcc_opseq
    import fwcc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic launch,
    input wire fwcc_code_t code_in,
    input wire logic suspend,
    input wire logic resume,
    input wire logic fl_done,
    output logic fl_start,
    output logic fl_abort,
    output fwcc_code_t fl_code,
    output logic finished
);
    typedef struct packed {
        fwcc_code_t phase;
        fwcc_code_t saved;
        logic start;
        logic abort;
        logic fin;
    } fwcc_seq_t;

    fwcc_seq_t s;
    fwcc_seq_t next_s;

    always_comb begin
        next_s = s;
        next_s.start = 1'b0;
        next_s.abort = 1'b0;
        next_s.fin = 1'b0;
        if (launch) begin
            next_s.phase = (code_in == op_erase) ? op_preprog : code_in;
            next_s.start = 1'b1;
        end else if (resume) begin
            // restart the phase that was halted
            next_s.phase = s.saved;
            next_s.saved = op_none;
            next_s.start = 1'b1;
        end else if (fl_done && s.phase != op_none) begin
            // completion wins over a suspend seen in the same cycle
            if (s.phase == op_preprog) begin
                next_s.phase = op_erase;
                next_s.start = 1'b1;
            end else begin
                next_s.phase = op_none;
                next_s.fin = 1'b1;
            end
        end else if (suspend && s.phase != op_none) begin
            next_s.saved = s.phase;
            next_s.phase = op_none;
            next_s.abort = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '{phase: op_none, saved: op_none, start: 1'b0, abort: 1'b0, fin: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign fl_start = s.start;
    assign fl_abort = s.abort;
    assign fl_code = s.phase;
    assign finished = s.fin;
endmodule
`default_nettype wire

// File: fwcc_ctrl.sv
// flash write command control: APB registers, launch, suspend and resume
//
// Summary of operation
// - write start launches every operation; hardware clears it at end or suspend.
// - write start is refused while the operation error flag is set.
// - writing zero to write start changes nothing.
// - suspend request halts program or erase, clears busy bits, back to read.
// - in program suspend only reads and program resume are accepted.
// - in erase suspend reads, erase resume and programs; those cannot suspend.
// - bit 13 selects 32-bit word program from address and data-0 holders.
// - bit 12 selects 64-bit double word program using data-0 and data-1.
// - bit 11 selects sector erase of chosen sectors in one bank; the code accepts extension sectors of banks 2 and 3 in one erase.
// - selected sectors are preprogrammed to zero before erase automatically.
// - bit 8 selects set protection from the holding registers.
// - set protection outside 0x0EDFB0..0x0EDFBF raises the sequence error flag.
// - bit 7 low picks extension module, high primary; cleared at end, but kept after a program run in erase suspend.
// - user writes to the test sector are blocked outside bootstrap mode; the code checks only erases from idle with bit 7 high, not programs.
// - write start sets busy bits of the banks being modified.
// - write start sets lock; locked registers read invalid, ignore writes.
//
// Decided for this implementation: the address map and register access over APB.
`include "fwcc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module fwcc_ctrl
    import fwcc_pkg::*;
#(
    parameter int ADDR_W = 24,
    parameter int SECT_W = 32
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bootstrap_mode,
    input wire logic fl_done,
    input wire logic fl_fail,
    output logic fl_start,
    output logic fl_abort,
    output fwcc_code_t fl_code,
    output logic fl_module,
    output logic [ADDR_W-1:0] fl_addr,
    output logic [31:0] fl_data0,
    output logic [31:0] fl_data1,
    output logic [SECT_W-1:0] fl_sectors,
    output logic [3:0] bank_busy,
    output logic lock
);
    typedef struct packed {
        logic write_start;
        logic suspend_req;
        logic sel_word;
        logic sel_dword;
        logic sel_erase;
        logic sel_protect;
        logic sel_module;
        logic [ADDR_W-1:0] addr;
        logic [31:0] data0;
        logic [31:0] data1;
        logic [SECT_W-1:0] sectors;
        logic op_error;
        logic seq_error;
        logic [3:0] busy;
        logic lock;
        fwcc_mode_t mode;
        fwcc_code_t run_op;
        fwcc_code_t suspend_request_bit_op;
        logic launch;
        logic resume;
        logic suspend;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } fwcc_state_t;

    fwcc_state_t s;
    fwcc_state_t next_s;
    logic seq_finished;

    // banks touched by an operation, bank 0 in bit 0
    function automatic logic [3:0] banks_of(input fwcc_code_t op, input logic primary,
                                            input logic [ADDR_W-1:0] a,
                                            input logic [SECT_W-1:0] sect);
        logic [3:0] b;
        b = `FWCC_RST_BUSY;
        case (op)
            op_word, op_dword: begin
                if (primary) begin
                    b[0] = ~a[`FWCC_BANK_ADDR_BIT];
                    b[1] = a[`FWCC_BANK_ADDR_BIT];
                end else begin
                    b[2] = ~a[`FWCC_BANK_ADDR_BIT];
                    b[3] = a[`FWCC_BANK_ADDR_BIT];
                end
            end
            op_erase: begin
                if (primary) begin
                    b[0] = 1'b1;
                end else begin
                    b[2] = |sect[`FWCC_SECT_B2_HI:0];
                    b[3] = |sect[`FWCC_SECT_B3_HI:`FWCC_SECT_B3_LO];
                end
            end
            // protection registers live in bank 2
            op_protect: b[2] = 1'b1;
            default: b = `FWCC_RST_BUSY;
        endcase
        return b;
    endfunction

    fwcc_opseq u_seq (
        .clk(clk),
        .nrst(nrst),
        .launch(s.launch),
        .code_in(s.run_op),
        .suspend(s.suspend),
        .resume(s.resume),
        .fl_done(fl_done),
        .fl_start(fl_start),
        .fl_abort(fl_abort),
        .fl_code(fl_code),
        .finished(seq_finished)
    );

    always_comb begin
        logic setup;
        logic wr;
        logic locked_err;
        logic known;
        logic [15:0] wd;
        logic [3:0] sel;
        logic one_hot;
        logic accept;
        logic bad_seq;
        fwcc_code_t op;
        logic [31:0] rd;
        setup = 1'b0;
        wr = 1'b0;
        locked_err = 1'b0;
        known = 1'b0;
        wd = pwdata[15:0];
        sel = {wd[`FWCC_BIT_WORD], wd[`FWCC_BIT_DWORD], wd[`FWCC_BIT_ERASE],
               wd[`FWCC_BIT_PROTECT]};
        one_hot = (sel == 4'h8) || (sel == 4'h4) || (sel == 4'h2) || (sel == 4'h1);
        accept = 1'b0;
        bad_seq = 1'b0;
        op = op_none;
        rd = `FWCC_RST_WORD;
        next_s = s;
        next_s.launch = 1'b0;
        next_s.resume = 1'b0;
        next_s.suspend = 1'b0;

        // bus answer is prepared in the setup cycle: zero wait states
        setup = psel && !penable;
        next_s.pready = setup;
        known = (paddr == `FWCC_OFS_CMD_HIGH) || (paddr == `FWCC_OFS_CMD_LOW) ||
                (paddr == `FWCC_OFS_ADDR) || (paddr == `FWCC_OFS_DATA0) ||
                (paddr == `FWCC_OFS_DATA1) || (paddr == `FWCC_OFS_SECTOR) ||
                (paddr == `FWCC_OFS_ERROR);
        // lock traps all but the low command word; suspend stays writable
        locked_err = s.lock && (paddr != `FWCC_OFS_CMD_LOW) &&
                     !(pwrite && paddr == `FWCC_OFS_CMD_HIGH);
        case (paddr)
            `FWCC_OFS_CMD_HIGH: begin
                rd[`FWCC_BIT_WRITE_START] = s.write_start;
                rd[`FWCC_BIT_SUSPEND] = s.suspend_req;
                rd[`FWCC_BIT_WORD] = s.sel_word;
                rd[`FWCC_BIT_DWORD] = s.sel_dword;
                rd[`FWCC_BIT_ERASE] = s.sel_erase;
                rd[`FWCC_BIT_PROTECT] = s.sel_protect;
                rd[`FWCC_BIT_MODULE] = s.sel_module;
            end
            `FWCC_OFS_CMD_LOW: begin
                rd[`FWCC_BIT_BUSY_B0] = s.busy[0];
                rd[`FWCC_BIT_BUSY_B1] = s.busy[1];
                rd[`FWCC_BIT_LOCK] = s.lock;
                rd[`FWCC_BIT_BUSY_B2] = s.busy[2];
                rd[`FWCC_BIT_BUSY_B3] = s.busy[3];
            end
            `FWCC_OFS_ADDR: rd[ADDR_W-1:0] = s.addr;
            `FWCC_OFS_DATA0: rd = s.data0;
            `FWCC_OFS_DATA1: rd = s.data1;
            `FWCC_OFS_SECTOR: rd[SECT_W-1:0] = s.sectors;
            `FWCC_OFS_ERROR: begin
                rd[`FWCC_BIT_OP_ERROR] = s.op_error;
                rd[`FWCC_BIT_SEQ_ERROR] = s.seq_error;
            end
            default: rd = `FWCC_RST_WORD;
        endcase
        if (setup) begin
            next_s.pslverr = !known || locked_err;
            next_s.prdata = locked_err ? `FWCC_INVALID_DATA : rd;
        end else if (s.pready) begin
            next_s.pslverr = 1'b0;
            next_s.prdata = `FWCC_RST_WORD;
        end

        // write takes effect only at the access edge that completes the transfer
        wr = psel && penable && s.pready && pwrite && !s.pslverr;

        if (wr && paddr == `FWCC_OFS_CMD_HIGH) begin
            next_s.suspend_req = wd[`FWCC_BIT_SUSPEND];
            if (s.lock) begin
                // a rising suspend request halts a running program or erase; set protection ignores it
                // programs started in erase suspend run in mode_pine and ignore it
                if (wd[`FWCC_BIT_SUSPEND] && !s.suspend_req && s.mode == mode_run &&
                    s.run_op != op_protect) begin
                    next_s.suspend = 1'b1;
                end
            end else begin
                // select bits are stored, write start is never cleared here
                next_s.sel_word = wd[`FWCC_BIT_WORD];
                next_s.sel_dword = wd[`FWCC_BIT_DWORD];
                next_s.sel_erase = wd[`FWCC_BIT_ERASE];
                next_s.sel_protect = wd[`FWCC_BIT_PROTECT];
                next_s.sel_module = wd[`FWCC_BIT_MODULE];
                op = wd[`FWCC_BIT_WORD] ? op_word :
                     wd[`FWCC_BIT_DWORD] ? op_dword :
                     wd[`FWCC_BIT_ERASE] ? op_erase :
                     wd[`FWCC_BIT_PROTECT] ? op_protect : op_none;
                // nothing is accepted while the operation error flag is set
                // nor while the suspend request is left set
                if (wd[`FWCC_BIT_WRITE_START] && !s.op_error && !wd[`FWCC_BIT_SUSPEND]) begin
                    bad_seq = !one_hot;
                    case (s.mode)
                        mode_idle: begin
                            accept = one_hot;
                        end
                        mode_psusp: begin
                            // only the resume of the suspended program
                            accept = one_hot && (op == s.suspend_request_bit_op);
                            bad_seq = !accept;
                        end
                        mode_esusp: begin
                            // erase resume, or a word or double word program
                            accept = one_hot && (op == op_erase || op == op_word ||
                                                 op == op_dword);
                            bad_seq = !accept;
                        end
                        default: accept = 1'b0;
                    endcase
                    // protection target outside the protection window
                    if (accept && op == op_protect &&
                        (s.addr < `FWCC_PROT_LO || s.addr > `FWCC_PROT_HI)) begin
                        accept = 1'b0;
                        bad_seq = 1'b1;
                    end
                    // erase needs at least one sector
                    // test sector only reachable in bootstrap mode for an erase from idle with bit 7 high
                    if (accept && op == op_erase && s.mode == mode_idle &&
                        (s.sectors == '0 || (wd[`FWCC_BIT_MODULE] && !bootstrap_mode &&
                                             s.sectors[`FWCC_BIT_TEST_SECTOR]))) begin
                        accept = 1'b0;
                        bad_seq = 1'b1;
                    end
                    if (accept) begin
                        next_s.write_start = 1'b1;
                        // busy bits of the banks under modification
                        next_s.busy = banks_of(op, wd[`FWCC_BIT_MODULE], s.addr, s.sectors);
                        // registers locked for the whole operation
                        next_s.lock = 1'b1;
                        next_s.run_op = op;
                        if (s.mode == mode_esusp && op != op_erase) begin
                            next_s.mode = mode_pine;
                            next_s.launch = 1'b1;
                        end else if (s.mode == mode_idle) begin
                            next_s.mode = mode_run;
                            next_s.launch = 1'b1;
                        end else begin
                            next_s.mode = mode_run;
                            next_s.resume = 1'b1;
                        end
                    end
                    if (bad_seq) begin
                        next_s.seq_error = 1'b1;
                    end
                end
            end
        end

        if (wr && !s.lock) begin
            case (paddr)
                `FWCC_OFS_ADDR: next_s.addr = pwdata[ADDR_W-1:0];
                `FWCC_OFS_DATA0: next_s.data0 = pwdata;
                `FWCC_OFS_DATA1: next_s.data1 = pwdata;
                `FWCC_OFS_SECTOR: next_s.sectors = pwdata[SECT_W-1:0];
                `FWCC_OFS_ERROR: begin
                    // write one to clear; a same-cycle set below still wins
                    if (pwdata[`FWCC_BIT_OP_ERROR]) begin
                        next_s.op_error = 1'b0;
                    end
                    if (pwdata[`FWCC_BIT_SEQ_ERROR] && !bad_seq) begin
                        next_s.seq_error = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        if (fl_fail) begin
            next_s.op_error = 1'b1;
        end

        if (seq_finished) begin
            // hardware clears write start, busy and lock at the end
            next_s.write_start = 1'b0;
            next_s.busy = `FWCC_RST_BUSY;
            next_s.lock = 1'b0;
            next_s.sel_word = 1'b0;
            // double word select cleared at completion
            next_s.sel_dword = 1'b0;
            if (s.mode == mode_pine) begin
                // back to erase suspend for the halted erase; erase, protect and module selects keep the program command's values
                next_s.mode = mode_esusp;
                next_s.run_op = op_erase;
            end else begin
                // erase select cleared after the erase
                next_s.sel_erase = 1'b0;
                next_s.sel_protect = 1'b0;
                // module select cleared at the end of the operation
                next_s.sel_module = 1'b0;
                next_s.mode = mode_idle;
                next_s.run_op = op_none;
            end
        end else if (s.suspend) begin
            // suspend returns the bank to read mode
            next_s.write_start = 1'b0;
            next_s.busy = `FWCC_RST_BUSY;
            next_s.lock = 1'b0;
            next_s.suspend_request_bit_op = s.run_op;
            next_s.mode = (s.run_op == op_erase) ? mode_esusp : mode_psusp;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '{write_start: 1'b0, suspend_req: 1'b0, sel_word: 1'b0, sel_dword: 1'b0,
                   sel_erase: 1'b0, sel_protect: 1'b0, sel_module: 1'b0,
                   addr: `FWCC_RST_ADDR, data0: `FWCC_RST_WORD, data1: `FWCC_RST_WORD,
                   sectors: '0, op_error: 1'b0, seq_error: 1'b0, busy: `FWCC_RST_BUSY,
                   lock: 1'b0, mode: mode_idle, run_op: op_none, suspend_request_bit_op: op_none,
                   launch: 1'b0, resume: 1'b0, suspend: 1'b0, pready: 1'b0,
                   pslverr: 1'b0, prdata: `FWCC_RST_WORD};
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign fl_module = s.sel_module;
    assign fl_addr = s.addr;
    assign fl_data0 = s.data0;
    assign fl_data1 = s.data1;
    assign fl_sectors = s.sectors;
    assign bank_busy = s.busy;
    assign lock = s.lock;
endmodule
`default_nettype wire

// File: placeholder_end.sv
// no further logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: fwcc_ctrl_assertions.sv
// port-level checks for the flash command block
`timescale 1ns/1ps
`default_nettype none
module fwcc_ctrl_checker
    import fwcc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic fl_done,
    input wire logic fl_start,
    input wire logic fl_abort,
    input wire fwcc_code_t fl_code,
    input wire logic fl_module,
    input wire logic [3:0] bank_busy,
    input wire logic lock
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire logic acc = psel && penable && pready;
    // completion or abort takes up to three edges to release the lock
    logic [2:0] hist;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) hist <= 3'h0;
        else hist <= {hist[1:0], fl_done | fl_abort};
    end
    property p_launch_start;
        $rose(lock) |=> fl_start;
    endproperty
    a_launch_start: assert property (p_launch_start) else $error("no start after lock");
    property p_busy_set;
        $rose(lock) |-> bank_busy != 4'h0;
    endproperty
    a_busy_set: assert property (p_busy_set) else $error("lock without busy");
    property p_abort_release;
        fl_abort |-> ##[1:2] (!lock && bank_busy == 4'h0);
    endproperty
    a_abort_release: assert property (p_abort_release) else $error("suspend kept lock");
    property p_done_release;
        fl_done && lock && fl_code inside {op_word, op_dword, op_erase, op_protect}
            |-> ##[1:3] !lock;
    endproperty
    a_done_release: assert property (p_done_release) else $error("end kept lock");
    property p_module_hold;
        lock && $past(lock) |-> $stable(fl_module);
    endproperty
    a_module_hold: assert property (p_module_hold) else $error("module moved");
    property p_locked_read;
        acc && !pwrite && lock && $past(lock) && paddr == 8'h0C
            |-> pslverr && prdata == 32'hFFFFFFFF;
    endproperty
    a_locked_read: assert property (p_locked_read) else $error("locked read valid");
    property p_zero_keeps;
        acc && pwrite && paddr == 8'h00 && pwdata[15:14] == 2'h0 && lock
            && hist == 3'h0 && !fl_done && !fl_abort |=> lock;
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("zero write ended op");
    property p_start_locked;
        fl_start |-> lock;
    endproperty
    a_start_locked: assert property (p_start_locked) else $error("start while unlocked");
    c_launch: cover property ($rose(lock));
    c_abort: cover property (fl_abort);
    c_preprog: cover property (fl_start && fl_code == op_preprog);
endmodule
`default_nettype wire

// File: fwcc_ctrl_tb.sv
// self-checking bench for the flash command block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR %0t: got %h expected %h", $time, a, b); end end
module fwcc_ctrl_tb
    import fwcc_pkg::*;
;
    logic clk, nrst, psel, penable, pwrite, bootstrap_mode, fl_done, fl_fail, re;
    logic [7:0] paddr;
    logic [31:0] pwdata, rq;
    wire logic [31:0] prdata, fl_data0, fl_data1, fl_sectors;
    wire logic pready, pslverr, fl_start, fl_abort, fl_module, lock;
    wire fwcc_code_t fl_code;
    wire logic [23:0] fl_addr;
    wire logic [3:0] bank_busy;
    int err_total = 0;
    int cmp_count = 0;
    fwcc_ctrl fwcc_ctrl_inst (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bootstrap_mode(bootstrap_mode), .fl_done(fl_done),
        .fl_fail(fl_fail), .fl_start(fl_start), .fl_abort(fl_abort), .fl_code(fl_code),
        .fl_module(fl_module), .fl_addr(fl_addr), .fl_data0(fl_data0), .fl_data1(fl_data1),
        .fl_sectors(fl_sectors), .bank_busy(bank_busy), .lock(lock));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic stop_test;
        if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n >= 16) begin
            err_total++;
            stop_test();
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        tmo(n);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
        apb(1'b0, a, 32'h00000000);
        `CHK(rq, d)
        `CHK(re, e)
    endtask
    // ab selects the abort pulse instead of the start pulse
    task automatic wait_hi(input logic ab, input fwcc_code_t c);
        int n;
        n = 0;
        while ((ab ? fl_abort : fl_start) !== 1'b1 && n < 16) begin
            @(posedge clk);
            n++;
        end
        tmo(n);
        if (!ab) `CHK(fl_code, c)
    endtask
    task automatic pulse(input logic f, input int wt);
        @(posedge clk);
        fl_done <= ~f;
        fl_fail <= f;
        @(posedge clk);
        fl_done <= 1'b0;
        fl_fail <= 1'b0;
        repeat (wt) @(posedge clk);
    endtask
    task automatic launch(input logic [31:0] cmd, input logic ok, input fwcc_code_t c);
        apb(1'b1, 8'h00, cmd);
        if (ok) begin
            wait_hi(1'b0, c);
            `CHK(lock, 1'b1)
        end else begin
            repeat (4) @(posedge clk);
            `CHK(lock, 1'b0)
        end
    endtask
    task automatic t_word;
        rd(8'h00, 32'h00000000, 1'b0);
        rd(8'h40, 32'h00000000, 1'b1);
        apb(1'b1, 8'h08, 32'h00000100);
        apb(1'b1, 8'h0C, 32'h12345678);
        launch(32'h0000A080, 1'b1, op_word);
        `CHK(bank_busy, 4'h1)
        `CHK(fl_module, 1'b1)
        `CHK(fl_data0, 32'h12345678)
        `CHK(fl_addr, 24'h000100)
        rd(8'h0C, 32'hFFFFFFFF, 1'b1);
        apb(1'b1, 8'h00, 32'h00000000);
        `CHK(lock, 1'b1)
        pulse(1'b0, 4);
        rd(8'h00, 32'h00000000, 1'b0);
    endtask
    task automatic t_ops;
        apb(1'b1, 8'h08, 32'h000EDFB4);
        apb(1'b1, 8'h10, 32'hCAFEF00D);
        launch(32'h00009080, 1'b1, op_dword);
        `CHK(fl_data1, 32'hCAFEF00D)
        pulse(1'b0, 4);
        rd(8'h00, 32'h00000000, 1'b0);
        launch(32'h00008180, 1'b1, op_protect);
        pulse(1'b0, 4);
        rd(8'h00, 32'h00000000, 1'b0);
        apb(1'b1, 8'h08, 32'h00000100);
        apb(1'b1, 8'h14, 32'h00000400);
        launch(32'h00008180, 1'b0, op_none);
        rd(8'h18, 32'h00000002, 1'b0);
        apb(1'b1, 8'h18, 32'h00000003);
        launch(32'h0000A880, 1'b0, op_none);
        rd(8'h18, 32'h00000002, 1'b0);
        apb(1'b1, 8'h18, 32'h00000003);
        launch(32'h00008880, 1'b0, op_none);
        rd(8'h18, 32'h00000002, 1'b0);
        apb(1'b1, 8'h18, 32'h00000003);
        bootstrap_mode <= 1'b1;
        launch(32'h00008880, 1'b1, op_preprog);
        `CHK(fl_sectors, 32'h00000400)
        pulse(1'b0, 0);
        wait_hi(1'b0, op_erase);
        pulse(1'b0, 4);
        rd(8'h00, 32'h00000000, 1'b0);
        bootstrap_mode <= 1'b0;
    endtask
    task automatic t_psusp;
        launch(32'h0000A080, 1'b1, op_word);
        apb(1'b1, 8'h00, 32'h00004000);
        wait_hi(1'b1, op_none);
        repeat (3) @(posedge clk);
        `CHK(bank_busy, 4'h0)
        rd(8'h00, 32'h00006080, 1'b0);
        launch(32'h0000E080, 1'b0, op_none);
        launch(32'h00008880, 1'b0, op_none);
        rd(8'h18, 32'h00000002, 1'b0);
        apb(1'b1, 8'h18, 32'h00000003);
        launch(32'h0000A080, 1'b1, op_word);
        pulse(1'b0, 4);
        rd(8'h00, 32'h00000000, 1'b0);
    endtask
    task automatic t_esusp;
        apb(1'b1, 8'h14, 32'h00000001);
        launch(32'h00008880, 1'b1, op_preprog);
        pulse(1'b0, 0);
        wait_hi(1'b0, op_erase);
        apb(1'b1, 8'h00, 32'h00004000);
        wait_hi(1'b1, op_none);
        repeat (3) @(posedge clk);
        `CHK(lock, 1'b0)
        launch(32'h0000A080, 1'b1, op_word);
        apb(1'b1, 8'h00, 32'h00004000);
        repeat (4) @(posedge clk);
        `CHK(lock, 1'b1)
        pulse(1'b0, 4);
        `CHK(lock, 1'b0)
        launch(32'h00008880, 1'b1, op_erase);
        pulse(1'b0, 4);
        rd(8'h00, 32'h00000000, 1'b0);
    endtask
    task automatic t_operr;
        launch(32'h0000A080, 1'b1, op_word);
        pulse(1'b1, 0);
        pulse(1'b0, 4);
        rd(8'h18, 32'h00000001, 1'b0);
        launch(32'h0000A080, 1'b0, op_none);
        apb(1'b1, 8'h18, 32'h00000001);
        launch(32'h0000A000, 1'b1, op_word);
        `CHK(fl_module, 1'b0)
        `CHK(bank_busy, 4'h4)
        pulse(1'b0, 4);
    endtask
    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        bootstrap_mode = 1'b0;
        fl_done = 1'b0;
        fl_fail = 1'b0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_word();
        t_ops();
        t_psusp();
        t_esusp();
        t_operr();
        stop_test();
    end
endmodule
bind fwcc_ctrl fwcc_ctrl_checker fwcc_ctrl_checker_inst (.clk(clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fl_done(fl_done),
    .fl_start(fl_start), .fl_abort(fl_abort), .fl_code(fl_code), .fl_module(fl_module),
    .bank_busy(bank_busy), .lock(lock));
`default_nettype wire
